/* design/gyro_spi_pkg.sv */
// Constants shared by the rate-sensor serial register port.
// Assumes the including design counts byte addresses of six bits and 16-bit frames.
package gyro_spi_pkg;

    // Byte addresses of the lower byte of each output register; the upper byte is one above.
    localparam logic [5:0] FLASH_COUNT_OFF = 6'h00;
    localparam logic [5:0] SUPPLY_OFF      = 6'h02;
    localparam logic [5:0] RATE_OFF        = 6'h04;
    localparam logic [5:0] AUX_OFF         = 6'h0a;
    localparam logic [5:0] TEMP_OFF        = 6'h0c;
    localparam logic [5:0] ANGLE_OFF       = 6'h0e;

    // Flagged output channels, in the order used by the channel arrays.
    localparam int CH_COUNT  = 5;
    localparam int CH_SUPPLY = 0;
    localparam int CH_RATE   = 1;
    localparam int CH_AUX    = 2;
    localparam int CH_TEMP   = 3;
    localparam int CH_ANGLE  = 4;
    localparam logic [5:0] CH_OFF [CH_COUNT] = '{SUPPLY_OFF, RATE_OFF, AUX_OFF, TEMP_OFF, ANGLE_OFF};

    // Frame layout.
    localparam int         FRAME_BITS    = 16;
    localparam logic [3:0] LAST_BIT      = 4'hf;
    localparam logic [3:0] ADDR_DONE_BIT = 4'h7;
    localparam logic [1:0] CMD_WRITE     = 2'h2;
    localparam logic [1:0] CMD_READ      = 2'h0;

    // Output register fields.
    localparam int          FRESH_BIT   = 15;
    localparam int          FAULT_BIT   = 14;
    localparam int          NARROW_W    = 12;
    localparam int          WIDE_W      = 14;
    localparam logic [13:0] RATE_POS_FS = 14'h1fff;
    localparam logic [13:0] RATE_NEG_FS = 14'h2000;

    // Reset values.
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [13:0] VALUE_RST = 14'h0000;

endpackage

/* design/gyro_spi_port.sv */
// Serial register port and output-data register file of a rate-sensor module.
// Assumes a serial master in clock mode 3 (clock idles high) and same-clock sample sources.
module gyro_spi_port (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic        sample_load,
    input  wire logic [11:0] supply_value,
    input  wire logic [13:0] rate_value,
    input  wire logic [11:0] aux_value,
    input  wire logic [11:0] temp_value,
    input  wire logic [13:0] angle_value,
    input  wire logic        fault_alarm_flag,
    input  wire logic        angle_clear,
    input  wire logic [15:0] flash_write_count,
    output logic             reg_wr_stb,
    output logic [5:0]       reg_wr_addr,
    output logic [7:0]       reg_wr_data
);

    // ---------------- Link side, clocked by the master's serial clock ----------------

    logic [3:0]  bit_cnt_r;
    logic [14:0] rx_r;
    logic [5:0]  rd_addr_r;
    logic        rd_req_tgl_r;
    logic        rd_pend_r;
    logic [5:0]  wr_addr_r;
    logic [7:0]  wr_data_r;
    logic        wr_req_tgl_r;
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic [15:0] resp_r;
    logic [15:0] tx_word_r;
    logic        dout_r;
    logic [15:0] core_word_r;
    logic        rd_ack_tgl_r;

    wire [15:0] rx_word   = {rx_r, din};
    wire [1:0]  head_cmd  = rx_r[6:5];
    wire        rd_start  = (bit_cnt_r == gyro_spi_pkg::ADDR_DONE_BIT) && (head_cmd == gyro_spi_pkg::CMD_READ);
    wire        frame_end = (bit_cnt_r == gyro_spi_pkg::LAST_BIT);
    wire        wr_frame  = frame_end && (rx_word[15:14] == gyro_spi_pkg::CMD_WRITE);
    wire        ack_done  = (ack_s2_r == rd_req_tgl_r);

    // Chip select high holds the frame counter at zero, so a partial frame is discarded.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_r <= 15'h0000;
        end else if (!cs_n) begin
            rx_r <= rx_word[14:0];
        end
    end

    // The read request leaves after the address byte, so the core has eight clocks to answer.
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_addr_r    <= 6'h00;
            rd_req_tgl_r <= 1'b0;
            rd_pend_r    <= 1'b0;
        end else if (!cs_n && rd_start) begin
            rd_addr_r    <= rx_word[5:0];
            rd_req_tgl_r <= ~rd_req_tgl_r;
            rd_pend_r    <= 1'b1;
        end else if (!cs_n && frame_end) begin
            rd_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_addr_r    <= 6'h00;
            wr_data_r    <= 8'h00;
            wr_req_tgl_r <= 1'b0;
        end else if (!cs_n && wr_frame) begin
            wr_addr_r    <= rx_word[13:8];
            wr_data_r    <= rx_word[7:0];
            wr_req_tgl_r <= ~wr_req_tgl_r;
        end
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= rd_ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // Any frame that was not a completed read returns zeros in the following frame.
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            resp_r <= gyro_spi_pkg::WORD_RST;
        end else if (!cs_n && frame_end) begin
            resp_r <= (rd_pend_r && ack_done) ? core_word_r : gyro_spi_pkg::WORD_RST;
        end
    end

    // The first falling edge of a frame loads the answer and shows its top bit before the first rise.
    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_word_r <= gyro_spi_pkg::WORD_RST;
            dout_r    <= 1'b0;
        end else if (!cs_n) begin
            if (bit_cnt_r == 4'h0) begin
                tx_word_r <= resp_r;
                dout_r    <= resp_r[15];
            end else begin
                dout_r <= tx_word_r[~bit_cnt_r];
            end
        end
    end

    assign dout    = dout_r;
    assign dout_oe = ~cs_n;

    // ---------------- Core side ----------------

    logic        rd_s1_r;
    logic        rd_s2_r;
    logic        rd_s3_r;
    logic        wr_s1_r;
    logic        wr_s2_r;
    logic        wr_s3_r;
    logic        reg_wr_stb_r;
    logic [5:0]  reg_wr_addr_r;
    logic [7:0]  reg_wr_data_r;
    logic [gyro_spi_pkg::CH_COUNT-1:0] fresh_r;
    logic [13:0] value_r [gyro_spi_pkg::CH_COUNT];
    logic [13:0] ch_in   [gyro_spi_pkg::CH_COUNT];
    logic [15:0] ch_word [gyro_spi_pkg::CH_COUNT];
    logic [gyro_spi_pkg::CH_COUNT-1:0] rd_hit;
    logic [15:0] sel_word;

    wire rd_evt     = rd_s2_r ^ rd_s3_r;
    wire wr_evt     = wr_s2_r ^ wr_s3_r;
    wire flash_hit  = (rd_addr_r[5:1] == gyro_spi_pkg::FLASH_COUNT_OFF[5:1]);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_s3_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
        end else begin
            rd_s1_r <= rd_req_tgl_r;
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
            wr_s1_r <= wr_req_tgl_r;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
        end
    end

    // Right-aligned fields; the spare top bits of narrow channels read as zero.
    assign ch_in[gyro_spi_pkg::CH_SUPPLY] = {2'h0, supply_value};
    assign ch_in[gyro_spi_pkg::CH_RATE]   = rate_value;
    assign ch_in[gyro_spi_pkg::CH_AUX]    = {2'h0, aux_value};
    assign ch_in[gyro_spi_pkg::CH_TEMP]   = {2'h0, temp_value};
    assign ch_in[gyro_spi_pkg::CH_ANGLE]  = angle_value;

    for (genvar i = 0; i < gyro_spi_pkg::CH_COUNT; i++) begin : g_ch
        wire clr_here = (i == gyro_spi_pkg::CH_ANGLE) && angle_clear;

        // Both byte addresses of a register decode to the same channel.
        assign rd_hit[i]  = (rd_addr_r[5:1] == gyro_spi_pkg::CH_OFF[i][5:1]);
        assign ch_word[i] = {fresh_r[i], fault_alarm_flag, value_r[i]};

        // A sample arriving in the cycle of the read wins, so no new data is lost.
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                fresh_r[i] <= 1'b0;
            end else if (sample_load) begin
                fresh_r[i] <= 1'b1;
            end else if (rd_evt && rd_hit[i]) begin
                fresh_r[i] <= 1'b0;
            end
        end

        // Reset doubles as the power-up clear of the angle.
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                value_r[i] <= gyro_spi_pkg::VALUE_RST;
            end else if (clr_here) begin
                value_r[i] <= gyro_spi_pkg::VALUE_RST;
            end else if (sample_load) begin
                value_r[i] <= ch_in[i];
            end
        end
    end

    // Unmapped addresses, including control registers kept elsewhere, read as zero.
    always_comb begin
        sel_word = flash_hit ? flash_write_count : gyro_spi_pkg::WORD_RST;
        for (int i = 0; i < gyro_spi_pkg::CH_COUNT; i++) begin
            if (rd_hit[i]) begin
                sel_word = ch_word[i];
            end
        end
    end

    // The held word is stable before the acknowledge toggle reaches the link side.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_word_r  <= gyro_spi_pkg::WORD_RST;
            rd_ack_tgl_r <= 1'b0;
        end else if (rd_evt) begin
            core_word_r  <= sel_word;
            rd_ack_tgl_r <= rd_s2_r;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_wr_stb_r  <= 1'b0;
            reg_wr_addr_r <= 6'h00;
            reg_wr_data_r <= 8'h00;
        end else begin
            reg_wr_stb_r <= wr_evt;
            if (wr_evt) begin
                reg_wr_addr_r <= wr_addr_r;
                reg_wr_data_r <= wr_data_r;
            end
        end
    end

    assign reg_wr_stb  = reg_wr_stb_r;
    assign reg_wr_addr = reg_wr_addr_r;
    assign reg_wr_data = reg_wr_data_r;

    // ---------------- Checks ----------------

    sequence wr_arrives;
        wr_evt ##1 reg_wr_stb_r;
    endsequence

    sequence rd_answered;
        rd_evt ##1 (rd_ack_tgl_r == rd_s3_r);
    endsequence

    fresh_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_load |=> (&fresh_r))
        else $error("fresh flags not set by a sample load");

    fresh_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rd_evt && rd_hit[gyro_spi_pkg::CH_RATE] && !sample_load) |=> !fresh_r[gyro_spi_pkg::CH_RATE])
        else $error("rate fresh flag survived its read");

    fresh_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (fresh_r[gyro_spi_pkg::CH_RATE] && !(rd_evt && rd_hit[gyro_spi_pkg::CH_RATE]))
        |=> fresh_r[gyro_spi_pkg::CH_RATE])
        else $error("rate fresh flag lost without its read");

    angle_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        angle_clear |=> (value_r[gyro_spi_pkg::CH_ANGLE] == gyro_spi_pkg::VALUE_RST))
        else $error("angle not cleared");

    supply_refresh_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_load |=> (value_r[gyro_spi_pkg::CH_SUPPLY] == $past(ch_in[gyro_spi_pkg::CH_SUPPLY])))
        else $error("supply sample not refreshed");

    rate_word_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rd_evt && rd_hit[gyro_spi_pkg::CH_RATE]) |=>
        (core_word_r[13:0] == $past(value_r[gyro_spi_pkg::CH_RATE]))
        && (core_word_r[14] == $past(fault_alarm_flag)))
        else $error("rate read returned wrong word");

    rd_ack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        rd_s2_r != rd_s3_r |-> rd_answered)
        else $error("read request not acknowledged");

    wr_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_arrives |=> !reg_wr_stb_r)
        else $error("write strobe longer than one cycle");

    frame_wrap_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        frame_end |=> (bit_cnt_r == 4'h0))
        else $error("frame counter did not wrap after sixteen bits");

    rd_launch_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        rd_start |=> (rd_req_tgl_r != $past(rd_req_tgl_r)) && (rd_addr_r == $past(rx_word[5:0])))
        else $error("read request not launched after the address byte");

    wr_capture_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        wr_frame |=> (wr_data_r == $past(rx_word[7:0])) && (wr_addr_r == $past(rx_word[13:8])))
        else $error("write frame captured wrongly");

    first_bit_a: assert property (@(negedge sclk) disable iff (cs_n || !arst_n)
        (bit_cnt_r == 4'h0) |=> (dout_r == tx_word_r[15]))
        else $error("frame did not start with the top bit");

    // A read whose answer has not crossed back by the last rise would go out as zeros.
    // The handshake therefore limits how fast the serial clock may run against the core clock.
    sequence answer_due;
        frame_end && rd_pend_r;
    endsequence

    rd_in_time_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        answer_due |-> ack_done)
        else $error("read answer missed the end of its request frame");

    resp_load_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        answer_due |=> (resp_r == $past(core_word_r)))
        else $error("read answer not queued for the next frame");

    resp_zero_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        (frame_end && !rd_pend_r) |=> (resp_r == gyro_spi_pkg::WORD_RST))
        else $error("frame without a read queued a nonzero answer");

    tx_load_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        (bit_cnt_r == 4'h0) |-> (tx_word_r == resp_r))
        else $error("frame did not start from the queued answer");

    // At each rise the bit on the pin must be the one the master is about to take.
    bit_order_a: assert property (@(posedge sclk) disable iff (cs_n || !arst_n)
        (dout_r == tx_word_r[~bit_cnt_r]))
        else $error("serial output bit out of order");

    flash_word_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rd_evt && flash_hit) |=> (core_word_r == $past(flash_write_count)))
        else $error("flash write count read returned wrong word");

    temp_pad_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rd_evt && rd_hit[gyro_spi_pkg::CH_TEMP]) |=> (core_word_r[13:12] == 2'h0))
        else $error("spare bits of a narrow channel not zero");

    angle_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sample_load && !angle_clear) |=> (value_r[gyro_spi_pkg::CH_ANGLE] == $past(angle_value)))
        else $error("angle sample not refreshed");

    wr_data_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_wr_stb_r |-> (reg_wr_addr_r == wr_addr_r) && (reg_wr_data_r == wr_data_r))
        else $error("write strobe carries the wrong byte");

endmodule // gyro_spi_port

/* sim/spi_master_model.sv */
// Behavioural serial master that drives the rate-sensor register port.
// Assumes clock mode 3 and a bench that resolves the data-out pin.
module spi_master_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // The clock stands high between frames, so the device sees no stray edges.
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--) begin
            #24 sclk = 1'b0;
            din = tx[i];
            #24 sclk = 1'b1;
            rx[i] = miso;
        end
    endtask

    task automatic sel();
        #7 cs_n = 1'b0;
        #30;
    endtask

    // Released data input toggles so a stale level never looks valid.
    task automatic desel();
        #24 cs_n = 1'b1;
        din = ~din;
        #100;
    endtask
endmodule // spi_master_model

/* sim/gyro_spi_register_port_test.sv */
// Self-checking bench for the rate-sensor serial register port.
// Assumes the master model above and the port's package constants.
module gyro_spi_register_port_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, arst_n, sample_load, fault_alarm_flag, angle_clear;
    logic [11:0] supply_value, aux_value, temp_value;
    logic [13:0] rate_value, angle_value;
    logic [15:0] flash_write_count, pend, rx;
    logic        sclk, cs_n, din, dout, dout_oe, reg_wr_stb;
    logic [5:0]  reg_wr_addr;
    logic [7:0]  reg_wr_data;
    wire         dout_w = dout_oe ? dout : 1'bz;
    int          bad_count, compares, stb_n;

    gyro_spi_port u_dut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .sample_load(sample_load), .supply_value(supply_value),
        .rate_value(rate_value), .aux_value(aux_value), .temp_value(temp_value), .angle_value(angle_value),
        .fault_alarm_flag(fault_alarm_flag), .angle_clear(angle_clear), .flash_write_count(flash_write_count),
        .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
    spi_master_model m (.sclk(sclk), .cs_n(cs_n), .din(din), .miso(dout_w));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) if (reg_wr_stb === 1'b1) stb_n <= stb_n + 1;

    task automatic close_out();
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic ld(input logic [11:0] s, input logic [13:0] r, input logic [11:0] a, input logic [11:0] t);
        @(posedge core_clk);
        supply_value <= s;
        rate_value <= r;
        aux_value <= a;
        temp_value <= t;
        sample_load <= 1'b1;
        @(posedge core_clk);
        sample_load <= 1'b0;
    endtask

    // Pipelined read: this frame returns the word asked for by the previous one.
    task automatic rq(input logic [5:0] a, input logic [15:0] e);
        m.frame({2'b00, a, 8'ha5}, rx);
        chk(rx, pend);
        pend = e;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        int s0;
        s0 = stb_n;
        m.frame({2'b10, a, d}, rx);
        chk(rx, pend);
        pend = 16'h0000;
        for (int n = 0; n < 40 && stb_n == s0; n++) @(posedge core_clk);
        if (stb_n == s0) begin
            bad_count++;
            close_out();
        end else begin
            chk({2'b00, reg_wr_addr, reg_wr_data}, {2'b00, a, d});
        end
    endtask

    initial begin
        arst_n = 1'b0;
        sample_load = 1'b0;
        angle_clear = 1'b0;
        fault_alarm_flag = 1'b0;
        supply_value = 12'h000;
        rate_value = 14'h0000;
        aux_value = 12'h000;
        temp_value = 12'h000;
        angle_value = 14'h2000;
        flash_write_count = 16'h9c3e;
        pend = 16'h0000;
        bad_count = 0;
        compares = 0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        ld(12'habc, 14'h1fff, 12'h123, 12'h456);
        m.sel();
        chk({15'h0000, dout_oe}, 16'h0001);
        rq(6'h01, 16'h9c3e);
        rq(6'h03, 16'h8abc);
        rq(6'h04, 16'h9fff);
        rq(6'h0a, 16'h8123);
        rq(6'h0c, 16'h8456);
        rq(6'h0f, 16'ha000);
        rq(6'h04, 16'h1fff);
        @(posedge core_clk);
        fault_alarm_flag <= 1'b1;
        rq(6'h0d, 16'h4456);
        rq(6'h20, 16'h0000);
        ld(12'h0f1, 14'h0155, 12'h222, 12'h333);
        rq(6'h05, 16'hc155);
        rq(6'h02, 16'hc0f1);
        @(posedge core_clk);
        angle_clear <= 1'b1;
        @(posedge core_clk);
        angle_clear <= 1'b0;
        rq(6'h0e, 16'hc000);
        wr(6'h2a, 8'h5c);
        wr(6'h2b, 8'h3d);
        m.frame(16'hffff, rx);
        chk(rx, pend);
        rq(6'h00, 16'h9c3e);
        rq(6'h00, 16'h9c3e);
        m.desel();
        chk({15'h0000, dout_oe}, 16'h0000);
        m.frame(16'hbf77, rx);
        repeat (20) @(posedge core_clk);
        chk({2'b00, reg_wr_addr, reg_wr_data}, 16'h2b3d);
        chk(stb_n[15:0], 16'h0002);
        m.sel();
        rq(6'h00, 16'h9c3e);
        m.desel();
        close_out();
    end
endmodule // gyro_spi_register_port_test
